/* File: src/seq_pkg.sv */
package seq_pkg;

  // ****************************************************************
  // Register map (word index, byte address is index times four)
  // ****************************************************************
  localparam logic [3:0] IDX_CONTROL_FLAGS = 4'h0;
  localparam logic [3:0] IDX_RISE_FIRST    = 4'h1;
  localparam logic [3:0] IDX_RISE_SECOND   = 4'h2;
  localparam logic [3:0] IDX_FALL_FIRST    = 4'h3;
  localparam logic [3:0] IDX_FALL_SECOND   = 4'h4;
  localparam logic [3:0] IDX_RISING_THR    = 4'h5;
  localparam logic [3:0] IDX_FALLING_THR   = 4'h6;
  localparam logic [3:0] IDX_RISE_DELAY    = 4'h7;
  localparam logic [3:0] IDX_FALL_DELAY    = 4'h8;
  localparam logic [3:0] IDX_REPEAT        = 4'h9;
  localparam logic [3:0] IDX_GAIN          = 4'ha;
  localparam logic [3:0] IDX_INTERLOCK     = 4'hb;
  localparam logic [3:0] IDX_STATUS        = 4'hc;
  localparam logic [3:0] IDX_SEQ_BASE      = 4'hd;
  localparam logic [3:0] IDX_SEQ_DATA      = 4'he;
  localparam int         NUM_REGS          = 15;
  localparam int         DATA_INDEX_BASE   = 64;

  // ****************************************************************
  // Control flag bits and reset values
  // ****************************************************************
  localparam int         BIT_BALLAST_EN  = 0;
  localparam int         BIT_CTRL_EN     = 1;
  localparam int         BIT_CUSTOM_EN   = 2;
  localparam int         BIT_RELATIVE    = 3;
  localparam logic [7:0] CTRL_WR_MASK    = 8'h0f;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] INTERLOCK_NONE  = 8'hff;
  localparam logic [7:0] GAIN_STANDARD   = 8'h00;
  localparam logic [7:0] REPEAT_OFF      = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ       = 50_000_000;
  localparam longint UNIT_A_SEC   = 15;
  localparam longint UNIT_MIN_SEC = 60;
  localparam longint TICKS_A      = UNIT_A_SEC * CLK_HZ;
  localparam longint TICKS_MIN    = UNIT_MIN_SEC * CLK_HZ;

  // ****************************************************************
  // Stored sequence
  // ****************************************************************
  localparam int SEQ_DEPTH = 16;
  localparam int SEQ_AW    = 4;

  typedef enum {ST_IDLE, ST_WAIT_A, ST_WAIT_B, ST_SEND} seq_state_t;

  typedef struct packed {
    logic       valid;
    logic       three_byte;
    logic [7:0] addr;
    logic [7:0] b1;
    logic [7:0] b2;
  } cmd_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avm_req_t;

endpackage : seq_pkg

/* File: src/threshold_triggered_command_sender.sv */
`timescale 1ns/1ps
// Operation
// - Triggers replay a stored list of commands, not just one.
// - Control bit 0 allows 2-byte ballast commands; cleared suppresses them.
// - Control bit 1 allows 3-byte controller commands; cleared suppresses them.
// - Control bit 2 enables custom lighting commands.
// - Control bit 3 set means relative thresholds, clear means absolute.
// - Passive-to-active crossing sends the rise pattern bytes.
// - Active-to-passive crossing sends the fall pattern bytes.
// - Output A fires on rising through, rising by, or binary 0 to 1.
// - Output B fires on falling through, falling by, or binary 1 to 0.
// - Rise delay counts in 15 second units.
// - Fall delay counts in one minute units.
// - Repeat interval in minutes resends the stored entries while control bit 1 is set; zero disables.
// - Gain zero selects standard sensitivity.
// - Interlock address 255 means none and is the reset value.
// - Parameters read at data index 64 through 75 as bytes 0 to 11.
module threshold_triggered_command_sender #(
  parameter longint TICKS_A   = seq_pkg::TICKS_A,
  parameter longint TICKS_MIN = seq_pkg::TICKS_MIN
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // Avalon-MM slave, word addressed
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Monitored value from the sensor front end (asynchronous)
  input  wire logic [7:0]  sensor_value_in,
  input  wire logic        binary_mode_in,
  // Command output to the bus transmitter
  output seq_pkg::cmd_t    cmd_out,
  input  wire logic        cmd_ready_in,
  // Settings used by the front end
  output logic      [7:0]  gain_out,
  output logic             auto_gain_out,
  output logic             custom_cmd_en_out,
  output logic      [7:0]  interlock_addr_out,
  output logic             interlock_en_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int SEQ_AW_L = seq_pkg::SEQ_AW;

  typedef struct packed {
    logic [seq_pkg::NUM_REGS-1:0][7:0]  regs;
    logic [seq_pkg::SEQ_DEPTH-1:0][23:0] seq;
    logic [7:0]                        s1;
    logic [7:0]                        s2;
    logic                              b1;
    logic                              b2;
    logic                              primed;
    logic [7:0]                        ref_val;
    logic                              active;
    seq_pkg::seq_state_t               st;
    logic                              pend_a;
    logic                              pend_b;
    logic                              sel_b;
    logic [7:0]                        units;
    logic [31:0]                       ticks;
    logic [SEQ_AW_L-1:0]               step;
    logic [7:0]                        rep_units;
    logic [31:0]                       rep_ticks;
    logic                              ack;
    logic [31:0]                       rdata;
    seq_pkg::cmd_t                     cmd;
  } st_t;

  st_t q_q;
  st_t d_d;

  function automatic logic [7:0] rd_byte(input st_t s, input logic [3:0] idx);
    rd_byte = (idx < 4'(seq_pkg::NUM_REGS)) ? s.regs[idx] : seq_pkg::RESET_BYTE;
  endfunction : rd_byte

  logic [7:0] cf;
  logic [7:0] thr_a;
  logic [7:0] thr_b;
  logic       rise_ev;
  logic       fall_ev;
  logic       bus_req;
  logic [7:0] wbyte;
  logic [4:0] seq_n;
  logic [23:0] entry;

  assign cf      = q_q.regs[seq_pkg::IDX_CONTROL_FLAGS];
  assign thr_a   = q_q.regs[seq_pkg::IDX_RISING_THR];
  assign thr_b   = q_q.regs[seq_pkg::IDX_FALLING_THR];
  assign bus_req = avs_read_in | avs_write_in;
  assign wbyte   = avs_writedata_in[7:0];
  // Sequence length lives in the status-adjacent base register low bits
  assign seq_n   = {1'b0, q_q.regs[seq_pkg::IDX_SEQ_BASE][3:0]};
  assign entry   = q_q.seq[q_q.step];

  // ****************************************************************
  // Threshold evaluation
  // ****************************************************************
  always_comb begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (q_q.primed) begin
      if (q_q.b2) begin
        rise_ev = q_q.s2[0] & ~q_q.active;
        fall_ev = ~q_q.s2[0] & q_q.active;
      end else if (cf[seq_pkg::BIT_RELATIVE]) begin
        rise_ev = (q_q.s2 > q_q.ref_val) &&
                  (9'(q_q.s2) - 9'(q_q.ref_val) >= 9'(thr_a));
        fall_ev = (q_q.s2 < q_q.ref_val) &&
                  (9'(q_q.ref_val) - 9'(q_q.s2) >= 9'(thr_b));
      end else begin
        rise_ev = ~q_q.active && (q_q.s2 >= thr_a);
        fall_ev = q_q.active && (q_q.s2 < thr_b);
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d_d = q_q;
    d_d.s1 = sensor_value_in;
    d_d.s2 = q_q.s1;
    d_d.b1 = binary_mode_in;
    d_d.b2 = q_q.b1;
    d_d.primed = 1'b1;
    d_d.ack = 1'b0;
    if (!q_q.primed) begin
      d_d.ref_val = q_q.s2;
    end

    // Register bus: one wait cycle, then answer
    if (bus_req && !q_q.ack) begin
      d_d.ack = 1'b1;
      d_d.rdata = {24'h00_0000, rd_byte(q_q, avs_address_in)};
      if (avs_address_in == seq_pkg::IDX_STATUS) begin
        d_d.rdata = {24'h00_0000, 3'b000, q_q.sel_b, q_q.pend_b,
                     q_q.pend_a, q_q.active, q_q.st == seq_pkg::ST_SEND};
      end
      if (avs_address_in == seq_pkg::IDX_SEQ_DATA) begin
        d_d.rdata = {8'h00, q_q.seq[q_q.regs[seq_pkg::IDX_SEQ_BASE][7:4]]};
      end
      if (avs_write_in && avs_byteenable_in[0]) begin
        if (avs_address_in == seq_pkg::IDX_CONTROL_FLAGS) begin
          d_d.regs[seq_pkg::IDX_CONTROL_FLAGS] = wbyte & seq_pkg::CTRL_WR_MASK;
        end else if (avs_address_in == seq_pkg::IDX_SEQ_DATA) begin
          d_d.seq[q_q.regs[seq_pkg::IDX_SEQ_BASE][7:4]] = avs_writedata_in[23:0];
        end else if (avs_address_in < seq_pkg::IDX_STATUS) begin
          d_d.regs[avs_address_in] = wbyte;
        end else if (avs_address_in == seq_pkg::IDX_SEQ_BASE) begin
          d_d.regs[seq_pkg::IDX_SEQ_BASE] = wbyte;
        end
      end
    end

    // Threshold crossings arm the pending outputs
    if (rise_ev) begin
      d_d.active = 1'b1;
      d_d.ref_val = q_q.s2;
      d_d.pend_a = 1'b1;
      d_d.pend_b = 1'b0;
    end else if (fall_ev) begin
      d_d.active = 1'b0;
      d_d.ref_val = q_q.s2;
      d_d.pend_b = 1'b1;
      d_d.pend_a = 1'b0;
    end

    // Command handshake
    if (q_q.cmd.valid && cmd_ready_in) begin
      d_d.cmd.valid = 1'b0;
    end

    unique case (q_q.st)
      seq_pkg::ST_IDLE: begin
        if (q_q.pend_a) begin
          d_d.pend_a = rise_ev | fall_ev ? d_d.pend_a : 1'b0;
          d_d.sel_b = 1'b0;
          d_d.units = q_q.regs[seq_pkg::IDX_RISE_DELAY];
          d_d.ticks = '0;
          d_d.st = seq_pkg::ST_WAIT_A;
        end else if (q_q.pend_b) begin
          d_d.pend_b = rise_ev | fall_ev ? d_d.pend_b : 1'b0;
          d_d.sel_b = 1'b1;
          d_d.units = q_q.regs[seq_pkg::IDX_FALL_DELAY];
          d_d.ticks = '0;
          d_d.st = seq_pkg::ST_WAIT_B;
        end else if (q_q.regs[seq_pkg::IDX_REPEAT] != seq_pkg::REPEAT_OFF
                     && q_q.rep_units >= q_q.regs[seq_pkg::IDX_REPEAT]
                     && seq_n != 5'h00
                     && cf[seq_pkg::BIT_CTRL_EN]) begin
          // Repeats replay the stored entries only, never the pattern pair
          d_d.rep_units = '0;
          d_d.step = SEQ_AW_L'(4'h1);
          d_d.st = seq_pkg::ST_SEND;
        end
      end
      seq_pkg::ST_WAIT_A, seq_pkg::ST_WAIT_B: begin
        if (q_q.units == '0) begin
          d_d.step = '0;
          d_d.st = seq_pkg::ST_SEND;
        end else if (q_q.st == seq_pkg::ST_WAIT_A
                     ? q_q.ticks == 32'(TICKS_A - 1)
                     : q_q.ticks == 32'(TICKS_MIN - 1)) begin
          d_d.ticks = '0;
          d_d.units = q_q.units - 8'h01;
        end else begin
          d_d.ticks = q_q.ticks + 32'h0000_0001;
        end
      end
      seq_pkg::ST_SEND: begin
        if (!q_q.cmd.valid || cmd_ready_in) begin
          d_d.cmd = '0;
          // Step 0 is the pattern pair, then stored entries follow
          if (q_q.step == '0 && cf[seq_pkg::BIT_BALLAST_EN]) begin
            d_d.cmd.valid = 1'b1;
            d_d.cmd.b1 = q_q.sel_b ? q_q.regs[seq_pkg::IDX_FALL_FIRST]
                                   : q_q.regs[seq_pkg::IDX_RISE_FIRST];
            d_d.cmd.b2 = q_q.sel_b ? q_q.regs[seq_pkg::IDX_FALL_SECOND]
                                   : q_q.regs[seq_pkg::IDX_RISE_SECOND];
          end else if (q_q.step != '0) begin
            // Entries: bit 23 marks a 3-byte controller command
            d_d.cmd.three_byte = entry[23];
            d_d.cmd.addr = {1'b0, entry[22:16]};
            d_d.cmd.b1 = entry[15:8];
            d_d.cmd.b2 = entry[7:0];
            d_d.cmd.valid = entry[23] ? cf[seq_pkg::BIT_CTRL_EN]
                                      : cf[seq_pkg::BIT_BALLAST_EN];
          end
          if (5'(q_q.step) >= seq_n) begin
            d_d.st = seq_pkg::ST_IDLE;
          end else begin
            d_d.step = q_q.step + 1'b1;
          end
        end
      end
    endcase

    // Repeat timer runs in minutes
    if (q_q.rep_ticks == 32'(TICKS_MIN - 1)) begin
      d_d.rep_ticks = '0;
      if (q_q.rep_units != 8'hff) begin
        d_d.rep_units = q_q.rep_units + 8'h01;
      end
    end else begin
      d_d.rep_ticks = q_q.rep_ticks + 32'h0000_0001;
    end

    if (srst_in) begin
      d_d = '0;
      d_d.st = seq_pkg::ST_IDLE;
      d_d.regs[seq_pkg::IDX_GAIN] = seq_pkg::GAIN_STANDARD;
      d_d.regs[seq_pkg::IDX_INTERLOCK] = seq_pkg::INTERLOCK_NONE;
    end
  end

  always_ff @(posedge clock_in) begin
    q_q <= d_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest_out = bus_req & ~q_q.ack;
  assign avs_readdata_out    = q_q.rdata;
  assign cmd_out             = q_q.cmd;
  assign gain_out            = q_q.regs[seq_pkg::IDX_GAIN];
  assign auto_gain_out       = q_q.regs[seq_pkg::IDX_GAIN] == seq_pkg::GAIN_STANDARD;
  assign custom_cmd_en_out   = cf[seq_pkg::BIT_CUSTOM_EN];
  assign interlock_addr_out  = q_q.regs[seq_pkg::IDX_INTERLOCK];
  assign interlock_en_out    = q_q.regs[seq_pkg::IDX_INTERLOCK] != seq_pkg::INTERLOCK_NONE;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ballast_gate;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.cmd.valid && !q_q.cmd.three_byte) |-> cf[seq_pkg::BIT_BALLAST_EN];
  endproperty
  a_ballast_gate: assert property (p_ballast_gate) else $error("ballast cmd while disabled");

  property p_ctrl_gate;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.cmd.valid && q_q.cmd.three_byte) |-> cf[seq_pkg::BIT_CTRL_EN];
  endproperty
  a_ctrl_gate: assert property (p_ctrl_gate) else $error("3-byte cmd while disabled");

  property p_custom;
    @(posedge clock_in) disable iff (srst_in)
      (avs_write_in && !q_q.ack && avs_byteenable_in[0] &&
       avs_address_in == seq_pkg::IDX_CONTROL_FLAGS)
        |=> custom_cmd_en_out == $past(avs_writedata_in[seq_pkg::BIT_CUSTOM_EN]);
  endproperty
  a_custom: assert property (p_custom) else $error("custom enable mismatch");

  property p_rise_sets_active;
    @(posedge clock_in) disable iff (srst_in)
      rise_ev |=> q_q.active && q_q.pend_a;
  endproperty
  a_rise_sets_active: assert property (p_rise_sets_active) else $error("rise lost");

  property p_fall_clears_active;
    @(posedge clock_in) disable iff (srst_in)
      fall_ev |=> !q_q.active && q_q.pend_b;
  endproperty
  a_fall_clears_active: assert property (p_fall_clears_active) else $error("fall lost");

  property p_interlock_reset;
    @(posedge clock_in) $fell(srst_in) |-> interlock_addr_out == seq_pkg::INTERLOCK_NONE;
  endproperty
  a_interlock_reset: assert property (p_interlock_reset) else $error("bad interlock reset");

  property p_delay_holds;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_WAIT_A && q_q.units != '0) |=> q_q.st == seq_pkg::ST_WAIT_A;
  endproperty
  a_delay_holds: assert property (p_delay_holds) else $error("sent before delay");

  property p_answer;
    @(posedge clock_in) disable iff (srst_in)
      (bus_req && avs_waitrequest_out) |=> !avs_waitrequest_out || !bus_req;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  property p_unit_a;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_WAIT_A && q_q.units != '0 && q_q.ticks == 32'(TICKS_A - 1))
        |=> q_q.units == $past(q_q.units) - 8'h01;
  endproperty
  a_unit_a: assert property (p_unit_a) else $error("rise delay unit wrong");

  property p_unit_b;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_WAIT_B && q_q.units != '0 && q_q.ticks == 32'(TICKS_MIN - 1))
        |=> q_q.units == $past(q_q.units) - 8'h01;
  endproperty
  a_unit_b: assert property (p_unit_b) else $error("fall delay unit wrong");

  property p_rise_pattern;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_SEND && q_q.step == '0 && !q_q.sel_b &&
       cf[seq_pkg::BIT_BALLAST_EN] && (!q_q.cmd.valid || cmd_ready_in))
        |=> q_q.cmd.valid && q_q.cmd.b1 == $past(q_q.regs[seq_pkg::IDX_RISE_FIRST])
            && q_q.cmd.b2 == $past(q_q.regs[seq_pkg::IDX_RISE_SECOND]);
  endproperty
  a_rise_pattern: assert property (p_rise_pattern) else $error("wrong rise pattern");

  property p_fall_pattern;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_SEND && q_q.step == '0 && q_q.sel_b &&
       cf[seq_pkg::BIT_BALLAST_EN] && (!q_q.cmd.valid || cmd_ready_in))
        |=> q_q.cmd.valid && q_q.cmd.b1 == $past(q_q.regs[seq_pkg::IDX_FALL_FIRST])
            && q_q.cmd.b2 == $past(q_q.regs[seq_pkg::IDX_FALL_SECOND]);
  endproperty
  a_fall_pattern: assert property (p_fall_pattern) else $error("wrong fall pattern");

  property p_seq_steps;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_SEND && (!q_q.cmd.valid || cmd_ready_in) &&
       5'(q_q.step) < seq_n)
        |=> q_q.st == seq_pkg::ST_SEND && q_q.step == $past(q_q.step) + 1'b1;
  endproperty
  a_seq_steps: assert property (p_seq_steps) else $error("sequence cut short");

  property p_repeat_off;
    @(posedge clock_in) disable iff (srst_in)
      (q_q.st == seq_pkg::ST_IDLE && !q_q.pend_a && !q_q.pend_b &&
       q_q.regs[seq_pkg::IDX_REPEAT] == seq_pkg::REPEAT_OFF) |=> q_q.st == seq_pkg::ST_IDLE;
  endproperty
  a_repeat_off: assert property (p_repeat_off) else $error("repeat while off");

endmodule : threshold_triggered_command_sender

/* File: sim/cmd_sink.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus transmitter model: takes one command per handshake
// ****************************************************************
module cmd_sink (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  // Command from the block
  input  seq_pkg::cmd_t   cmd_in,
  input  wire logic [3:0] stall_in,
  output logic            cmd_ready_out
);
  seq_pkg::cmd_t got[$];
  logic [3:0]    wait_q;

  // Stall lets the bench test slow acceptance as well as prompt
  always @(posedge clock_in) begin
    if (srst_in) begin
      cmd_ready_out <= 1'b0;
      wait_q        <= 4'h0;
    end else if (cmd_ready_out && cmd_in.valid) begin
      got.push_back(cmd_in);
      cmd_ready_out <= 1'b0;
      wait_q        <= 4'h0;
    end else if (cmd_in.valid) begin
      if (wait_q >= stall_in) begin
        cmd_ready_out <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : cmd_sink

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic          clock_in;
  logic          srst_in;
  logic [3:0]    avs_address_in;
  logic          avs_read_in;
  logic          avs_write_in;
  logic [31:0]   avs_writedata_in;
  logic [3:0]    avs_byteenable_in;
  logic [31:0]   avs_readdata_out;
  logic          avs_waitrequest_out;
  logic [7:0]    sensor_value_in;
  logic          binary_mode_in;
  seq_pkg::cmd_t cmd_out;
  logic          cmd_ready_in;
  logic [7:0]    gain_out;
  logic          auto_gain_out;
  logic          custom_cmd_en_out;
  logic [7:0]    interlock_addr_out;
  logic          interlock_en_out;
  logic [3:0]    stall;
  logic [31:0]   rv;
  int            n_mismatch;
  int            compares;
  int            rd_i;
  localparam logic [31:0] NOADDR = 32'h0300_ffff;
  localparam logic [31:0] FULL   = 32'h03ff_ffff;

  // Short counts keep the delay and repeat timers within the run
  threshold_triggered_command_sender #(.TICKS_A(4), .TICKS_MIN(8))
    i_threshold_triggered_command_sender (
    .clock_in(clock_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .sensor_value_in(sensor_value_in), .binary_mode_in(binary_mode_in),
    .cmd_out(cmd_out), .cmd_ready_in(cmd_ready_in), .gain_out(gain_out),
    .auto_gain_out(auto_gain_out), .custom_cmd_en_out(custom_cmd_en_out),
    .interlock_addr_out(interlock_addr_out), .interlock_en_out(interlock_en_out));

  cmd_sink i_cmd_sink (.clock_in(clock_in), .srst_in(srst_in), .cmd_in(cmd_out),
    .stall_in(stall), .cmd_ready_out(cmd_ready_in));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out;
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [3:0] idx, input logic rd, input logic [31:0] wd);
    int n;
    @(posedge clock_in);
    avs_address_in   <= idx;
    avs_read_in      <= rd;
    avs_write_in     <= ~rd;
    avs_writedata_in <= wd;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    rv = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    if (avs_waitrequest_out !== 1'b0) begin
      n_mismatch++;
      close_out();
    end
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(idx, 1'b0, {24'h00_0000, d});
  endtask : wr

  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
    bus(idx, 1'b1, 32'h0000_0000);
    check(rv, exp);
  endtask : rdc

  task automatic sv(input logic [7:0] v);
    @(posedge clock_in);
    sensor_value_in <= v;
  endtask : sv

  task automatic expect_cmd(input logic [25:0] exp, input logic [31:0] mask);
    int n;
    n = 0;
    while (i_cmd_sink.got.size() <= rd_i && n < 400) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 400) begin
      n_mismatch++;
      close_out();
    end
    check({6'h00, i_cmd_sink.got[rd_i]} & mask, {6'h00, exp} & mask);
    rd_i++;
  endtask : expect_cmd

  // Nothing new may reach the transmitter for n cycles
  task automatic quiet(input int n);
    repeat (n) @(posedge clock_in);
    check(32'(i_cmd_sink.got.size()), 32'(rd_i));
  endtask : quiet

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0] cfg [12];
    cfg = '{8'h01, 8'h11, 8'h22, 8'h33, 8'h44, 8'h80, 8'h40, 8'h00, 8'h00, 8'h00,
            8'h00, 8'hff};
    n_mismatch = 0;
    compares = 0;
    rd_i = 0;
    stall = 4'h0;
    srst_in = 1'b1;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'hf;
    sensor_value_in = 8'h00;
    binary_mode_in = 1'b0;
    repeat (6) @(posedge clock_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      rdc(4'(i), 32'h0000_0000);
    end
    rdc(seq_pkg::IDX_INTERLOCK, 32'h0000_00ff);
    check({31'h0, auto_gain_out}, 32'h1);
    check({31'h0, interlock_en_out}, 32'h0);
    for (int i = 0; i < 12; i++) begin
      wr(4'(i), 8'hf0 + 8'(i));
    end
    for (int i = 1; i < 12; i++) begin
      rdc(4'(i), 32'h0000_00f0 + 32'(i));
    end
    rdc(4'h0, 32'h0000_0000);
    wr(4'hf, 8'h55);
    rdc(4'hf, 32'h0000_0000);
    check({22'h0, gain_out, auto_gain_out, interlock_en_out}, 32'h0000_03e9);
    check({24'h0, interlock_addr_out}, 32'h0000_00fb);
    wr(4'h0, 8'hf4);
    rdc(4'h0, 32'h0000_0004);
    check({31'h0, custom_cmd_en_out}, 32'h1);
    for (int i = 0; i < 12; i++) begin
      wr(4'(i), cfg[i]);
    end
    sv(8'h90);
    expect_cmd({2'b10, 8'h00, 8'h11, 8'h22}, NOADDR);
    sv(8'h50);
    quiet(30);
    sv(8'h20);
    expect_cmd({2'b10, 8'h00, 8'h33, 8'h44}, NOADDR);
    wr(4'h0, 8'h00);
    sv(8'h90);
    quiet(30);
    sv(8'h20);
    quiet(30);
    wr(4'h0, 8'h01);
    stall <= 4'h3;
    wr(seq_pkg::IDX_RISE_DELAY, 8'h03);
    sv(8'h90);
    quiet(16);
    expect_cmd({2'b10, 8'h00, 8'h11, 8'h22}, NOADDR);
    wr(seq_pkg::IDX_FALL_DELAY, 8'h02);
    sv(8'h20);
    quiet(12);
    expect_cmd({2'b10, 8'h00, 8'h33, 8'h44}, NOADDR);
    wr(seq_pkg::IDX_RISE_DELAY, 8'h00);
    wr(seq_pkg::IDX_FALL_DELAY, 8'h00);
    wr(4'h0, 8'h09);
    wr(seq_pkg::IDX_RISING_THR, 8'h30);
    wr(seq_pkg::IDX_FALLING_THR, 8'h30);
    sv(8'h40);
    quiet(30);
    sv(8'h80);
    expect_cmd({2'b10, 8'h00, 8'h11, 8'h22}, NOADDR);
    sv(8'h40);
    expect_cmd({2'b10, 8'h00, 8'h33, 8'h44}, NOADDR);
    @(posedge clock_in);
    binary_mode_in <= 1'b1;
    wr(4'h0, 8'h01);
    sv(8'h41);
    expect_cmd({2'b10, 8'h00, 8'h11, 8'h22}, NOADDR);
    sv(8'h40);
    expect_cmd({2'b10, 8'h00, 8'h33, 8'h44}, NOADDR);
    wr(seq_pkg::IDX_SEQ_BASE, 8'h12);
    bus(seq_pkg::IDX_SEQ_DATA, 1'b0, 32'h0095_a55a);
    wr(seq_pkg::IDX_SEQ_BASE, 8'h22);
    bus(seq_pkg::IDX_SEQ_DATA, 1'b0, 32'h0000_6677);
    wr(4'h0, 8'h03);
    sv(8'h41);
    expect_cmd({2'b10, 8'h00, 8'h11, 8'h22}, NOADDR);
    expect_cmd({2'b11, 8'h15, 8'ha5, 8'h5a}, FULL);
    expect_cmd({2'b10, 8'h00, 8'h66, 8'h77}, NOADDR);
    wr(4'h0, 8'h01);
    sv(8'h40);
    expect_cmd({2'b10, 8'h00, 8'h33, 8'h44}, NOADDR);
    expect_cmd({2'b10, 8'h00, 8'h66, 8'h77}, NOADDR);
    quiet(40);
    wr(seq_pkg::IDX_REPEAT, 8'h01);
    wr(4'h0, 8'h03);
    expect_cmd({2'b11, 8'h15, 8'ha5, 8'h5a}, FULL);
    expect_cmd({2'b10, 8'h00, 8'h66, 8'h77}, NOADDR);
    wr(seq_pkg::IDX_REPEAT, 8'h00);
    repeat (40) @(posedge clock_in);
    rd_i = i_cmd_sink.got.size();
    quiet(100);
    close_out();
  end
endmodule : testbench
